// File: chan_ctrl_pkg.sv
// Shared constants and carriers for the per-channel receiver and equalizer control bank
package chan_ctrl_pkg;
    localparam int          NUM_CHAN       = 8;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 8;
    localparam int          EQ_W           = 5;
    localparam int          CHAN_SHIFT     = 4;
    localparam logic [7:0]  CHAN0_OFFSET   = 8'h00;
    localparam logic [7:0]  CHAN1_OFFSET   = 8'h10;
    localparam logic [7:0]  CHAN2_OFFSET   = 8'h20;
    localparam logic [7:0]  CHAN3_OFFSET   = 8'h30;
    localparam logic [7:0]  CHAN4_OFFSET   = 8'h40;
    localparam logic [7:0]  CHAN_STRIDE    = 8'h10;
    localparam logic [3:0]  CTRL_SUBREG    = 4'h0;
    localparam int          RX_ON_BIT      = 5;
    localparam int          EQ_LSB         = 0;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic [7:0]  CTRL_RW_MASK   = 8'hff;
    localparam logic [7:0]  UNMAPPED_READ  = 8'h00;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic              rvalid;
    } host_rsp_t;
endpackage

// File: chan_reg_mem.sv
// Small register store for the eight channel control bytes, registered read data
`timescale 1ns/1ns
`default_nettype none
module chan_reg_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 8,
    parameter int AW    = 3
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata,
    output logic      [DEPTH*WIDTH-1:0] flat
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    initial begin
        if (DEPTH > (1 << AW)) $error("chan_reg_mem: DEPTH exceeds address range");
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            rdata <= '0;
        end else begin
            if (we) begin
                mem_r[waddr] <= wdata;
            end
            rdata <= (we && waddr == raddr) ? wdata : mem_r[raddr];
        end
    end

    generate
        for (genvar g = 0; g < DEPTH; g++) begin : g_flat
            assign flat[g*WIDTH +: WIDTH] = mem_r[g];
        end
    endgenerate
endmodule
`default_nettype wire

// File: chan_rx_eq_ctrl.sv
// Per-channel receiver power-on and equalizer code control bank
`timescale 1ns/1ns
`default_nettype none
module chan_rx_eq_ctrl
    import chan_ctrl_pkg::*;
#(
    parameter int CHANNELS = chan_ctrl_pkg::NUM_CHAN
) (
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire chan_ctrl_pkg::host_req_t    req,
    output chan_ctrl_pkg::host_rsp_t         rsp,
    input  wire logic                        host_mode,
    input  wire logic                        ball_grid_pkg,
    input  wire logic                        shared_receiver_enable_pin,
    output logic [CHANNELS-1:0]              receiver_power_on,
    output logic [CHANNELS*EQ_W-1:0]         equalizer_code
);
    import chan_ctrl_pkg::*;

    initial begin
        if (CHANNELS < 1 || CHANNELS > NUM_CHAN) $error("chan_rx_eq_ctrl: CHANNELS out of range");
    end

    typedef struct packed {
        logic [2:0]                pin_sync;
        logic                      pin_level;
        logic                      rvalid;
        logic [DATA_W-1:0]         rdata;
        logic [CHANNELS-1:0]       rx_on;
        logic [CHANNELS*EQ_W-1:0]  eq;
    } state_t;

    state_t     s_r;
    state_t     s_nxt;
    logic [1:0] rst_sync_r;
    logic       rst_n;
    assign rst_n = rst_sync_r[1];

    // Tells whether an address selects the control register of an existing channel
    function automatic logic hit(input logic [ADDR_W-1:0] a);
        hit = (a[CHAN_SHIFT-1:0] == CTRL_SUBREG) && (32'(a[ADDR_W-1:CHAN_SHIFT]) < CHANNELS);
    endfunction

    logic                      wr_hit;
    logic [2:0]                chan_idx;
    logic [CHANNELS*DATA_W-1:0] flat;

    assign chan_idx = req.addr[CHAN_SHIFT+2:CHAN_SHIFT];
    assign wr_hit   = req.wr && hit(req.addr);

    chan_reg_mem #(
        .DEPTH (CHANNELS),
        .WIDTH (DATA_W),
        .AW    (3)
    ) u_mem (
        .clk   (clk),
        .rst_n (rst_n),
        .we    (wr_hit),
        .waddr (chan_idx),
        .wdata (req.wdata & CTRL_RW_MASK),
        .raddr (chan_idx),
        .rdata (),
        .flat  (flat)
    );

    always_comb begin
        s_nxt          = s_r;
        s_nxt.pin_sync = {s_r.pin_sync[1:0], shared_receiver_enable_pin};
        // Change accepted only once the last two stages agree
        if (s_r.pin_sync[2] == s_r.pin_sync[1]) begin
            s_nxt.pin_level = s_r.pin_sync[2];
        end
        s_nxt.rvalid   = req.rd;
        // Read data is registered here so the port comes straight from a flop; it holds until the next read
        if (req.rd) begin
            if (!hit(req.addr)) begin
                s_nxt.rdata = UNMAPPED_READ;
            end else if (wr_hit) begin
                s_nxt.rdata = req.wdata & CTRL_RW_MASK;
            end else begin
                s_nxt.rdata = flat[32'(chan_idx)*DATA_W +: DATA_W];
            end
        end
        for (int c = 0; c < CHANNELS; c++) begin
            if (!host_mode) begin
                s_nxt.rx_on[c] = ball_grid_pkg ? s_nxt.pin_level : 1'b1;
            end else begin
                s_nxt.rx_on[c] = flat[c*DATA_W + RX_ON_BIT];
            end
            s_nxt.eq[c*EQ_W +: EQ_W] = flat[c*DATA_W + EQ_LSB +: EQ_W];
        end
    end

    // Reset release is synchronised separately; its sync stages cannot reset themselves
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r.pin_sync  <= 3'b000;
            s_r.pin_level <= 1'b0;
            s_r.rvalid    <= 1'b0;
            s_r.rdata     <= '0;
            s_r.rx_on     <= '0;
            s_r.eq        <= '0;
        end else begin
            s_r.pin_sync  <= s_nxt.pin_sync;
            s_r.pin_level <= s_nxt.pin_level;
            s_r.rvalid    <= s_nxt.rvalid;
            s_r.rdata     <= s_nxt.rdata;
            s_r.rx_on     <= s_nxt.rx_on;
            s_r.eq        <= s_nxt.eq;
        end
    end

    always_comb begin
        rsp.rvalid = s_r.rvalid;
        rsp.rdata  = s_r.rdata;
    end
    assign receiver_power_on = s_r.rx_on;
    assign equalizer_code    = s_r.eq;

    a_rx_on_write: assert property (@(posedge clk) disable iff (!rst_n)
        host_mode && $past(host_mode) && req.wr && req.addr == CHAN0_OFFSET
        |-> ##2 receiver_power_on[0] == $past(req.wdata[RX_ON_BIT], 2)) else $error("rx on bit not applied");
    a_rx_off_write: assert property (@(posedge clk) disable iff (!rst_n)
        host_mode ##1 host_mode && req.wr && req.addr == CHAN1_OFFSET && !req.wdata[RX_ON_BIT]
        ##1 host_mode ##1 host_mode |-> !receiver_power_on[1]) else $error("rx off not applied");
    a_rx_isolated: assert property (@(posedge clk) disable iff (!rst_n)
        host_mode && $past(host_mode, 2) && req.wr && req.addr == CHAN2_OFFSET
        ##1 !req.wr ##1 1'b1 |-> receiver_power_on[3] == $past(receiver_power_on[3], 2)) else $error("rx leak to other channel");
    // Hardware-mode settings held for two samples
    sequence s_hw_small;
        (!host_mode && !ball_grid_pkg)[*2];
    endsequence

    sequence s_hw_ball;
        (!host_mode && ball_grid_pkg)[*2];
    endsequence

    // Write to channel four, then no overwrite in the following cycle
    sequence s_ch4_write_alone;
        req.wr && req.addr == CHAN4_OFFSET ##1 !(req.wr && req.addr == CHAN4_OFFSET);
    endsequence

    // Write to channel three immediately followed by a read of it
    sequence s_ch3_write_then_read;
        req.wr && req.addr == CHAN3_OFFSET ##1 req.rd && !req.wr && req.addr == CHAN3_OFFSET;
    endsequence

    a_hw_small: assert property (@(posedge clk) disable iff (!rst_n)
        s_hw_small |=> &receiver_power_on) else $error("receivers not forced on");
    // Receivers follow the filtered pin level that is registered alongside them
    a_hw_ball: assert property (@(posedge clk) disable iff (!rst_n)
        s_hw_ball |=> receiver_power_on == {CHANNELS{s_r.pin_level}}) else $error("shared enable wrong");
    a_eq_code: assert property (@(posedge clk) disable iff (!rst_n)
        s_ch4_write_alone
        |=> equalizer_code[4*EQ_W +: EQ_W] == $past(req.wdata[EQ_W-1:0], 2)) else $error("eq code mismatch");
    a_reset_zero: assert property (@(posedge clk) $rose(rst_n) |-> equalizer_code == '0 && rsp.rdata == '0) else $error("nonzero after reset");
    a_read_back: assert property (@(posedge clk) disable iff (!rst_n)
        s_ch3_write_then_read
        |=> rsp.rvalid && rsp.rdata == $past(req.wdata, 2)) else $error("readback mismatch");
    a_rvalid_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        req.rd |=> rsp.rvalid) else $error("read not answered");
    // An unmapped write must leave every stored channel byte untouched
    a_unmapped_write: assert property (@(posedge clk) disable iff (!rst_n)
        req.wr && !hit(req.addr) |=> flat == $past(flat)) else $error("unmapped write changed a channel");
endmodule
`default_nettype wire

// File: chan_rx_eq_ctrl_test.sv
// Register-level testbench for the channel receiver and equalizer control bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module chan_rx_eq_ctrl_test;
    import chan_ctrl_pkg::*;
    logic                     clk;
    logic                     nrst;
    host_req_t                req;
    host_rsp_t                rsp;
    logic                     host_mode;
    logic                     ball_grid_pkg;
    logic                     shared_receiver_enable_pin;
    logic [NUM_CHAN-1:0]      receiver_power_on;
    logic [NUM_CHAN*EQ_W-1:0] equalizer_code;
    logic [NUM_CHAN*EQ_W-1:0] exp_eq;
    int                       error_cnt;
    int                       num_checks;
    int                       cycles;

    chan_rx_eq_ctrl chan_rx_eq_ctrl_inst (
        .clk                        (clk),
        .nrst                       (nrst),
        .req                        (req),
        .rsp                        (rsp),
        .host_mode                  (host_mode),
        .ball_grid_pkg              (ball_grid_pkg),
        .shared_receiver_enable_pin (shared_receiver_enable_pin),
        .receiver_power_on          (receiver_power_on),
        .equalizer_code             (equalizer_code)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic final_report;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // A hang is cut short well past the roughly 110 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= d;
        @(posedge clk);
        req.wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        req.rd   <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req.rd   <= 1'b0;
        #1;
        `CHK(rsp.rvalid, 1'b1)
        `CHK(rsp.rdata, e)
    endtask

    // Write, then read the same address on the very next cycle
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= d;
        @(posedge clk);
        req.wr    <= 1'b0;
        req.rd    <= 1'b1;
        @(posedge clk);
        req.rd    <= 1'b0;
        #1;
        `CHK(rsp.rvalid, 1'b1)
        `CHK(rsp.rdata, d)
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Distinct byte per channel: odd channels powered, bits 7:6 also exercised
    function automatic logic [7:0] val(input int c);
        return 8'(((c & 1) << 5) | ((c * 5 + 3) & 31) | (c << 6));
    endfunction

    initial begin
        nrst = 1'b0;
        req = '0;
        host_mode = 1'b1;
        ball_grid_pkg = 1'b0;
        shared_receiver_enable_pin = 1'b0;
        error_cnt = 0;
        num_checks = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        settle(3);
        `CHK(receiver_power_on, 8'h00)
        `CHK(equalizer_code, 40'h00_0000_0000)
        for (int c = 0; c < NUM_CHAN; c++) rd_chk(8'(c * 16), 8'h00);
        for (int c = 0; c < NUM_CHAN; c++) begin
            wr(8'(c * 16), val(c));
            exp_eq[c*EQ_W +: EQ_W] = 5'(val(c) & 8'h1f);
        end
        settle(2);
        `CHK(receiver_power_on, 8'haa)
        `CHK(equalizer_code, exp_eq)
        for (int c = 0; c < NUM_CHAN; c++) rd_chk(8'(c * 16), val(c));
        // Unmapped write must not disturb channel 0 nor anything else
        wr(8'h81, 8'hff);
        rd_chk(8'h81, 8'h00);
        wr(8'h10, 8'h1f);
        wr(8'h20, 8'h20);
        exp_eq[5 +: 5] = 5'h1f;
        exp_eq[10 +: 5] = 5'h00;
        wr_rd(8'h30, 8'h3a);
        exp_eq[15 +: 5] = 5'h1a;
        settle(2);
        `CHK(receiver_power_on, 8'hac)
        `CHK(equalizer_code, exp_eq)
        rd_chk(8'h10, 8'h1f);
        @(posedge clk);
        host_mode <= 1'b0;
        settle(8);
        `CHK(receiver_power_on, 8'hff)
        `CHK(equalizer_code, exp_eq)
        @(posedge clk);
        ball_grid_pkg <= 1'b1;
        settle(8);
        `CHK(receiver_power_on, 8'h00)
        @(posedge clk);
        shared_receiver_enable_pin <= 1'b1;
        settle(8);
        `CHK(receiver_power_on, 8'hff)
        @(posedge clk);
        host_mode <= 1'b1;
        settle(8);
        `CHK(receiver_power_on, 8'hac)
        final_report();
    end
endmodule
`default_nettype wire
